// ### rtl/tlp_line_port.v
// Transmit line output port: line clock, positive/data and negative outputs
//
// Notes on behaviour
// RULE_01 - The line clock output toggles only while the line pin enable is set.
// RULE_02 - The line clock is the default timing reference for the data and negative outputs.
// RULE_03 - A setting inverts the polarity of the line clock output.
// RULE_04 - The line clock runs at the DS3 or E3 rate, each within 20 ppm.
// RULE_05 - In bipolar modes with pins enabled the positive output is high for a positive pulse.
// RULE_06 - Outputs update on the rising reference edge, or the falling edge when inverted.
// RULE_07 - The reference is one of line clock, tx clock out, tx clock in, rx line clock, rx clock out.
// RULE_08 - With the internal line interface unit on, the positive output can be disabled.
// RULE_09 - In unipolar mode the raw data bit drives the shared output and can be inverted.
// RULE_10 - The positive/data output carries the DS3 or E3 bit rate, each within 20 ppm.
// RULE_11 - In bipolar modes with pins enabled the negative output is high for a negative pulse.
// RULE_12 - With the pin enable clear the clock and data outputs rest low.
`timescale 1ns/1ps
`include "tlp_defs.vh"
module tlp_line_port #(
  parameter SYNC_STAGES = 2,
  parameter BUF_DEPTH = 2
) (
  // Core clock and reset
  input wire core_clk_in,
  input wire rst_in,
  // Clocks sampled from outside the core domain
  input wire tx_line_clock_src_in,
  input wire tx_clock_output_in,
  input wire tx_clock_input_in,
  input wire rx_line_clock_input_in,
  input wire rx_clock_output_in,
  // Configuration levels
  input wire tx_line_pins_enable_in,
  input wire [`TLP_MODE_W-1:0] line_mode_in,
  input wire [`TLP_REF_W-1:0] ref_select_in,
  input wire ref_invert_in,
  input wire clock_invert_in,
  input wire data_invert_in,
  input wire line_interface_unit_enable_in,
  input wire pos_disable_in,
  // Symbol stream from the encoder
  input wire sym_valid_in,
  input wire sym_pos_in,
  input wire sym_neg_in,
  output wire sym_ready_out,
  // Line pins
  output wire tx_line_clock_out,
  output wire tx_positive_pulse_out,
  output wire tx_negative_pulse_out,
  // Status
  output wire underrun_out
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  wire [`TLP_CLK_COUNT-1:0] clk_raw;
  wire [`TLP_CLK_COUNT-1:0] clk_sync;
  reg ref_level;
  reg ref_inv;
  reg ref_prev_reg;
  wire ref_edge;
  wire buf_valid;
  wire [`TLP_SYM_W-1:0] buf_data;
  wire buf_ready;
  wire bipolar;
  wire pos_gate;
  // Output side
  reg line_clk_reg;
  reg pos_reg;
  reg pos_next;
  reg neg_reg;
  reg neg_next;
  reg underrun_reg;
  // Edge detector warm-up after reset or a new reference
  reg [1:0] warm_reg;
  reg [`TLP_REF_W-1:0] sel_prev_reg;
  reg inv_prev_reg;
  wire cfg_change;
  wire warm_done;

  // --------------------------------------------------------------------
  // Clock input synchronisers
  // --------------------------------------------------------------------

  // Gather the external clocks in selection order
  assign clk_raw[`TLP_CLK_BIT_TX_LINE] = tx_line_clock_src_in;
  assign clk_raw[`TLP_CLK_BIT_TX_CLKO] = tx_clock_output_in;
  assign clk_raw[`TLP_CLK_BIT_TX_CLKI] = tx_clock_input_in;
  assign clk_raw[`TLP_CLK_BIT_RX_LINE] = rx_line_clock_input_in;
  assign clk_raw[`TLP_CLK_BIT_RX_CLKO] = rx_clock_output_in;

  // One synchroniser chain per clock; only the last stage is read
  genvar gi;
  generate
    for (gi = 0; gi < `TLP_CLK_COUNT; gi = gi + 1)
    begin : g_sync
      reg [SYNC_STAGES-1:0] chain_reg;
      always @(posedge core_clk_in)
      begin
        if (rst_in)
          chain_reg <= {SYNC_STAGES{`TLP_RESET_LEVEL}};
        else
          chain_reg <= {chain_reg[SYNC_STAGES-2:0], clk_raw[gi]};
      end
      assign clk_sync[gi] = chain_reg[SYNC_STAGES-1];
    end
  endgenerate

  // --------------------------------------------------------------------
  // Line clock output
  // --------------------------------------------------------------------

  // Gated and optionally inverted copy of the line clock source
  always @(posedge core_clk_in)
  begin
    if (rst_in)
      line_clk_reg <= `TLP_RESET_LEVEL;
    // RULE_01 RULE_12 enable gates clock
    else if (!tx_line_pins_enable_in)
      line_clk_reg <= `TLP_RESET_LEVEL;
    // RULE_03 clock polarity invert
    else
      line_clk_reg <= clk_sync[`TLP_CLK_BIT_TX_LINE] ^ clock_invert_in;
  end

  // RULE_04 rate follows source
  assign tx_line_clock_out = line_clk_reg;

  // --------------------------------------------------------------------
  // Reference clock selection and edge detection
  // --------------------------------------------------------------------

  // Pick the reference and whether it counts as inverted
  always @*
  begin
    ref_level = clk_sync[`TLP_CLK_BIT_TX_LINE];
    ref_inv = clock_invert_in;
    // RULE_07 reference clock select
    case (ref_select_in)
      // RULE_02 line clock default
      `TLP_REF_TX_LINE_CLOCK:
      begin
        ref_level = clk_sync[`TLP_CLK_BIT_TX_LINE];
        ref_inv = clock_invert_in;
      end
      `TLP_REF_TX_CLOCK_OUTPUT:
      begin
        ref_level = clk_sync[`TLP_CLK_BIT_TX_CLKO];
        ref_inv = ref_invert_in;
      end
      `TLP_REF_TX_CLOCK_INPUT:
      begin
        ref_level = clk_sync[`TLP_CLK_BIT_TX_CLKI];
        ref_inv = ref_invert_in;
      end
      `TLP_REF_RX_LINE_CLOCK_INPUT:
      begin
        ref_level = clk_sync[`TLP_CLK_BIT_RX_LINE];
        ref_inv = ref_invert_in;
      end
      `TLP_REF_RX_CLOCK_OUTPUT:
      begin
        ref_level = clk_sync[`TLP_CLK_BIT_RX_CLKO];
        ref_inv = ref_invert_in;
      end
      default:
      begin
        ref_level = clk_sync[`TLP_CLK_BIT_TX_LINE];
        ref_inv = clock_invert_in;
      end
    endcase
  end

  // Previous reference level for edge finding
  always @(posedge core_clk_in)
  begin
    if (rst_in)
      ref_prev_reg <= `TLP_RESET_LEVEL;
    else
      ref_prev_reg <= ref_level;
  end

  // --------------------------------------------------------------------
  // Edge detector warm-up
  // --------------------------------------------------------------------

  // A new reference or polarity restarts the warm-up
  assign cfg_change = (ref_select_in != sel_prev_reg) |
    (ref_inv != inv_prev_reg);
  assign warm_done = (warm_reg == 2'h3);

  // No false edge while the chain or edge flop still hold stale levels, except in the cycle the reference select changes
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      warm_reg <= 2'h0;
      sel_prev_reg <= `TLP_REF_TX_LINE_CLOCK;
      inv_prev_reg <= `TLP_RESET_LEVEL;
    end
    else
    begin
      sel_prev_reg <= ref_select_in;
      inv_prev_reg <= ref_inv;
      if (cfg_change)
        warm_reg <= 2'h0;
      else if (!warm_done)
        warm_reg <= warm_reg + 2'h1;
    end
  end

  // RULE_06 rising or falling edge
  assign ref_edge = warm_done &
    (ref_inv ? (ref_prev_reg & ~ref_level) : (ref_level & ~ref_prev_reg));

  // --------------------------------------------------------------------
  // Symbol buffer
  // --------------------------------------------------------------------

  // Drained one symbol per update edge while the pins are enabled
  assign buf_ready = ref_edge & tx_line_pins_enable_in;

  tlp_sym_buf #(
    .WIDTH(`TLP_SYM_W),
    .DEPTH(BUF_DEPTH)
  ) u_sym_buf (
    .clk_in(core_clk_in),
    .rst_in(rst_in),
    .wr_valid_in(sym_valid_in),
    .wr_data_in({sym_neg_in, sym_pos_in}),
    .wr_ready_out(sym_ready_out),
    .rd_valid_out(buf_valid),
    .rd_data_out(buf_data),
    .rd_ready_in(buf_ready)
  );

  // --------------------------------------------------------------------
  // Output coding
  // --------------------------------------------------------------------

  // Three bipolar codes share one path
  assign bipolar = (line_mode_in != `TLP_MODE_UNIPOLAR);
  // RULE_08 positive output disable
  assign pos_gate = ~(line_interface_unit_enable_in & pos_disable_in);

  // Next values of the positive/data and negative outputs
  always @*
  begin
    pos_next = pos_reg;
    neg_next = neg_reg;
    // RULE_12 idle low when disabled
    if (!tx_line_pins_enable_in)
    begin
      pos_next = `TLP_RESET_LEVEL;
      neg_next = `TLP_RESET_LEVEL;
    end
    // RULE_10 one bit per edge
    else if (ref_edge)
    begin
      if (!buf_valid)
      begin
        pos_next = 1'h0; // No word: no pulse
        neg_next = 1'h0;
      end
      else if (bipolar)
      begin
        // RULE_05 positive pulse output
        pos_next = buf_data[`TLP_SYM_POS] & pos_gate;
        // RULE_11 negative pulse output
        neg_next = buf_data[`TLP_SYM_NEG];
      end
      else
      begin
        // RULE_09 unipolar data invert
        pos_next = (buf_data[`TLP_SYM_POS] ^ data_invert_in) & pos_gate;
        neg_next = 1'h0;
      end
    end
  end

  // Output and underrun flops
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      pos_reg <= `TLP_RESET_LEVEL;
      neg_reg <= `TLP_RESET_LEVEL;
      underrun_reg <= `TLP_RESET_LEVEL;
    end
    else
    begin
      pos_reg <= pos_next;
      neg_reg <= neg_next;
      underrun_reg <= buf_ready & ~buf_valid;
    end
  end

  assign tx_positive_pulse_out = pos_reg;
  assign tx_negative_pulse_out = neg_reg;
  assign underrun_out = underrun_reg;

endmodule // tlp_line_port

// ### rtl/tlp_defs.vh
// Constants for the transmit line output port
`ifndef TLP_DEFS_VH
`define TLP_DEFS_VH

// ----------------------------------------------------------------------
// Line coding modes
// ----------------------------------------------------------------------
`define TLP_MODE_W 2
`define TLP_MODE_B3ZS 2'h0
`define TLP_MODE_HDB3 2'h1
`define TLP_MODE_AMI 2'h2
`define TLP_MODE_UNIPOLAR 2'h3

// ----------------------------------------------------------------------
// Reference clock selection codes
// ----------------------------------------------------------------------
`define TLP_REF_W 3
`define TLP_REF_TX_LINE_CLOCK 3'h0
`define TLP_REF_TX_CLOCK_OUTPUT 3'h1
`define TLP_REF_TX_CLOCK_INPUT 3'h2
`define TLP_REF_RX_LINE_CLOCK_INPUT 3'h3
`define TLP_REF_RX_CLOCK_OUTPUT 3'h4

// Bit position of each sampled clock in the clock vector
`define TLP_CLK_COUNT 5
`define TLP_CLK_BIT_TX_LINE 0
`define TLP_CLK_BIT_TX_CLKO 1
`define TLP_CLK_BIT_TX_CLKI 2
`define TLP_CLK_BIT_RX_LINE 3
`define TLP_CLK_BIT_RX_CLKO 4

// ----------------------------------------------------------------------
// Symbol word layout in the buffer
// ----------------------------------------------------------------------
`define TLP_SYM_W 2
`define TLP_SYM_POS 0
`define TLP_SYM_NEG 1

// ----------------------------------------------------------------------
// Line rates (clock in Hz, data in bit/s) and tolerance in ppm
// ----------------------------------------------------------------------
`define TLP_DS3_RATE_HZ 44736000
`define TLP_E3_RATE_HZ 34368000
`define TLP_RATE_TOL_PPM 20

// Reset value of every output and pipeline flop
`define TLP_RESET_LEVEL 1'h0

`endif

// ### rtl/tlp_sym_buf.v
// Two-entry symbol buffer with valid/ready on both sides
`timescale 1ns/1ps
module tlp_sym_buf #(
  parameter WIDTH = 2,
  parameter DEPTH = 2
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Fill side
  input wire wr_valid_in,
  input wire [WIDTH-1:0] wr_data_in,
  output wire wr_ready_out,
  // Drain side
  output wire rd_valid_out,
  output wire [WIDTH-1:0] rd_data_out,
  input wire rd_ready_in
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg wr_ptr_reg;
  reg rd_ptr_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;

  // Honest full and empty flags
  assign wr_ready_out = (count_reg != 2'h2);
  assign rd_valid_out = (count_reg != 2'h0);
  assign rd_data_out = mem_reg[rd_ptr_reg];
  assign push = wr_valid_in & wr_ready_out;
  assign pop = rd_valid_out & rd_ready_in;

  // Storage and pointers
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_ptr_reg <= 1'h0;
      rd_ptr_reg <= 1'h0;
      count_reg <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem_reg[wr_ptr_reg] <= wr_data_in;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (push & ~pop)
        count_reg <= count_reg + 2'h1;
      else if (pop & ~push)
        count_reg <= count_reg - 2'h1;
    end
  end

endmodule // tlp_sym_buf

// ### test/tlp_line_port_monitor.sv
// Assertion checker for the transmit line output port
`timescale 1ns/1ps
`include "tlp_defs.vh"
module tlp_line_port_monitor (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_in,
  // Watched inputs
  input wire tx_line_clock_src_in,
  input wire tx_line_pins_enable_in,
  input wire [`TLP_MODE_W-1:0] line_mode_in,
  input wire [`TLP_REF_W-1:0] ref_select_in,
  input wire clock_invert_in,
  input wire line_interface_unit_enable_in,
  input wire pos_disable_in,
  input wire sym_valid_in,
  // Watched outputs
  input wire sym_ready_out,
  input wire tx_line_clock_out,
  input wire tx_positive_pulse_out,
  input wire tx_negative_pulse_out,
  input wire underrun_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wire en = tx_line_pins_enable_in;
  wire inv = clock_invert_in;
  // Cycles since reset, saturating, so history never reaches into reset
  reg [2:0] up_reg;
  wire [2:0] up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
  always @(posedge core_clk_in)
    up_reg <= rst_in ? 3'h0 : up_next;
  wire ok = (up_reg == 3'h7);
  // Word taken while the pins are off
  sequence take_s;
    sym_valid_in && sym_ready_out && !en;
  endsequence
  // Pins on and clock inversion steady for three cycles
  sequence steady_s;
    ok && $past(en) && $past(en, 2) && $past(en, 3) && $past(inv, 2) == $past(inv)
      && $past(inv, 3) == $past(inv);
  endsequence
  dis_low_a: assert property (
    !en |=> !(tx_line_clock_out || tx_positive_pulse_out || tx_negative_pulse_out))
    else $error("line outputs active while disabled");
  line_clk_a: assert property (
    steady_s |-> tx_line_clock_out == ($past(tx_line_clock_src_in, 3) ^ $past(inv)))
    else $error("line clock not the delayed source");
  pos_upd_a: assert property (
    ok && $changed(tx_positive_pulse_out) && $past(en) && $past(ref_select_in) == 3'h0
      && !$past(inv) |-> $rose(tx_line_clock_out))
    else $error("positive output moved off the reference edge");
  unipolar_neg_a: assert property (
    $rose(tx_negative_pulse_out) |-> $past(line_mode_in) != `TLP_MODE_UNIPOLAR)
    else $error("negative output pulsed in unipolar mode");
  pos_off_a: assert property (
    $rose(tx_positive_pulse_out) |-> !($past(line_interface_unit_enable_in) && $past(pos_disable_in)))
    else $error("positive output rose while disabled");
  under_one_a: assert property (
    underrun_out |=> !underrun_out)
    else $error("underrun longer than one cycle");
  under_zero_a: assert property (
    underrun_out |-> !tx_positive_pulse_out && !tx_negative_pulse_out && $past(en))
    else $error("underrun without idle outputs");
  fill_full_a: assert property (
    take_s ##1 take_s |=> !sym_ready_out)
    else $error("ready after two words while disabled");
endmodule // tlp_line_port_monitor

bind tlp_line_port tlp_line_port_monitor mon (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .tx_line_clock_src_in(tx_line_clock_src_in),
  .tx_line_pins_enable_in(tx_line_pins_enable_in), .line_mode_in(line_mode_in),
  .ref_select_in(ref_select_in), .clock_invert_in(clock_invert_in),
  .line_interface_unit_enable_in(line_interface_unit_enable_in),
  .pos_disable_in(pos_disable_in), .sym_valid_in(sym_valid_in), .sym_ready_out(sym_ready_out),
  .tx_line_clock_out(tx_line_clock_out), .tx_positive_pulse_out(tx_positive_pulse_out),
  .tx_negative_pulse_out(tx_negative_pulse_out), .underrun_out(underrun_out));

// ### test/tlp_liu_model.sv
// Far-side model: free-running line clock source
`timescale 1ns/1ps
module tlp_liu_model #(
  parameter HALF_NS = 400,
  parameter START_NS = 37
) (
  // Line clock toward the port
  output reg line_src_out
);
  // Offset so source edges never meet core clock edges
  initial
  begin
    line_src_out = 1'h0;
    #START_NS;
    forever #HALF_NS line_src_out = ~line_src_out;
  end
endmodule // tlp_liu_model

// ### test/tb_transmit_line_output_port.sv
// Self-checking bench for the transmit line output port
`timescale 1ns/1ps
module tb_transmit_line_output_port;
  reg clk = 1'h0;
  reg rst = 1'h1;
  reg alt = 1'h0;
  reg en, rinv, cinv, dinv, liu, pdis, sv, sp, sn, pl;
  reg [1:0] mode;
  reg [2:0] rsel;
  reg [15:0] rows [0:13];
  reg [15:0] r;
  reg [2:0] hs;
  reg m;
  wire src, rdy, lclk, pos, neg, und;
  integer err_count = 0;
  integer checked = 0;
  integer i, k, n;
  // Core clock and an unrelated reference clock
  always #50 clk = ~clk;
  always #400 alt = ~alt;
  tlp_liu_model far (.line_src_out(src));
  tlp_line_port uut (
    .core_clk_in(clk), .rst_in(rst), .tx_line_clock_src_in(src),
    .tx_clock_output_in(alt & (rsel == 3'h1)), .tx_clock_input_in(alt & (rsel == 3'h2)),
    .rx_line_clock_input_in(alt & (rsel == 3'h3)), .rx_clock_output_in(alt & (rsel == 3'h4)),
    .tx_line_pins_enable_in(en), .line_mode_in(mode), .ref_select_in(rsel),
    .ref_invert_in(rinv), .clock_invert_in(cinv), .data_invert_in(dinv),
    .line_interface_unit_enable_in(liu), .pos_disable_in(pdis), .sym_valid_in(sv),
    .sym_pos_in(sp), .sym_neg_in(sn), .sym_ready_out(rdy), .tx_line_clock_out(lclk),
    .tx_positive_pulse_out(pos), .tx_negative_pulse_out(neg), .underrun_out(und));
  task tick;
  begin
    @(posedge clk);
    #5;
  end
  endtask
  task chk(input got, input exp);
  begin
    checked = checked + 1;
    if (got !== exp)
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      err_count = err_count + 1;
  end
  endtask
  task do_reset;
  begin
    rst = 1'h1;
    repeat (3) tick;
    rst = 1'h0;
  end
  endtask
  task wrap_up;
  begin
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  // Watchdog, several times the expected run
  initial
  begin
    #200000;
    err_count = err_count + 1;
    wrap_up;
  end
  // Main sequence
  initial
  begin
    {en, rinv, cinv, dinv, liu, pdis, sv, sp, sn, pl} = 10'h000;
    mode = 2'h0;
    rsel = 3'h0;
    // Digits: {rsel,rinv} {cinv,mode,dinv} {liu,pdis,pos,neg} {en,exp pos,exp neg,0}
    rows[0] = 16'h002C;
    rows[1] = 16'h221A;
    rows[2] = 16'h542C;
    rows[3] = 16'h663C;
    rows[4] = 16'h8728;
    rows[5] = 16'h070C;
    rows[6] = 16'h00E8;
    rows[7] = 16'h07C8;
    rows[8] = 16'h006C;
    rows[9] = 16'h082C;
    rows[10] = 16'h0020;
    rows[11] = 16'hA02C;
    rows[12] = 16'h941A;
    rows[13] = 16'h00AC;
    repeat (3) tick;
    chk(lclk | pos | neg | und, 1'h0);
    chk(rdy, 1'h1);
    rst = 1'h0;
    tick;
    chk(lclk | pos | neg | und, 1'h0);
    $display("reset test done");
    for (i = 0; i < 14; i = i + 1)
    begin
      r = rows[i];
      do_reset;
      {rsel, rinv} = r[15:12];
      {cinv, mode, dinv} = r[11:8];
      {liu, pdis, sp, sn} = r[7:4];
      en = r[3];
      sv = 1'h1;
      n = 0;
      m = 1'h0;
      // Three reference periods, counting rises and tracking the delayed source
      for (k = 0; k < 24; k = k + 1)
      begin
        tick;
        n = n + (lclk & ~pl);
        pl = lclk;
        hs = {hs[1:0], src};
        if (k >= 3 && lclk !== ((hs[2] ^ cinv) & en))
          m = 1'h1;
      end
      chk(m, 1'h0);
      chk(pos, r[2]);
      chk(neg, r[1]);
      chk(n > 0, r[3]);
      en = 1'h0;
      tick;
      chk(lclk | pos | neg, 1'h0);
      $display("row %0d done", i);
    end
    // Fill while disabled, then drain with the writer stalled
    do_reset;
    {rsel, rinv, cinv, mode, dinv, liu, pdis, sn} = 11'h000;
    sp = 1'h1;
    repeat (3) tick;
    chk(rdy, 1'h0);
    sv = 1'h0;
    en = 1'h1;
    k = 0;
    while (und !== 1'h1 && k < 40)
    begin
      tick;
      k = k + 1;
    end
    chk(und, 1'h1);
    chk(pos, 1'h0);
    chk(rdy, 1'h1);
    $display("fill and drain test done");
    wrap_up;
  end
endmodule // tb_transmit_line_output_port
